// file: hw/psr_regs.vh
`ifndef PSR_REGS_VH
`define PSR_REGS_VH

// register offsets
`define PSR_OFS_GOOD_STATUS   8'h18
`define PSR_OFS_GOOD_MASK     8'h19
`define PSR_OFS_UV_FLAGS      8'h1a
`define PSR_OFS_OV_FLAGS      8'h1b
`define PSR_OFS_PSAVE_SEL     8'h1c
`define PSR_OFS_SEQ_SEL       8'h1d
`define PSR_OFS_CH6_CFG       8'h1e

// field positions
`define PSR_BIT_EN_PIN        7
`define PSR_BIT_CH6_BUCK_ONLY 4
`define PSR_BIT_CH6_VTH_HI    1
`define PSR_BIT_CH6_VTH_LO    0

// implemented-bit masks; everything else reads zero
`define PSR_MSK_7CH           8'h7f
`define PSR_MSK_6CH           8'h3f
`define PSR_MSK_CH6_CFG       8'h13

// fixed reset values (fuse-loaded registers take fuse inputs instead)
`define PSR_RST_UV_FLAGS      7'h00
`define PSR_RST_OV_FLAGS      6'h00
`define PSR_RST_BYTE          8'h00

// bus address of the device on the two-wire link (value is arbitrary)
`define PSR_I2C_ADDR          7'h2a

// two-wire engine state codes
`define PSR_ST_IDLE           4'h0
`define PSR_ST_ADDR           4'h1
`define PSR_ST_ACK_A          4'h2
`define PSR_ST_PTR            4'h3
`define PSR_ST_ACK_P          4'h4
`define PSR_ST_WDATA          4'h5
`define PSR_ST_ACK_W          4'h6
`define PSR_ST_RDATA          4'h7
`define PSR_ST_MACK           4'h8

// bits per byte on the wire
`define PSR_BYTE_BITS         4'h8

`endif

// file: hw/psr_i2c_slave.v
`include "psr_regs.vh"

module psr_i2c_slave (
    input  wire       clk,        // system clock
    input  wire       rst_n,      // synchronous reset, active low
    input  wire       scl_i,      // serial clock level
    input  wire       sda_i,      // serial data level
    output wire       sda_o,      // serial data out, always low
    output wire       sda_oe,     // high while pulling data low
    output wire [7:0] reg_addr,   // current register pointer
    output reg        wr_stb,     // one-cycle write strobe
    output reg  [7:0] wr_data,    // write data byte
    input  wire [7:0] rd_data     // read data at reg_addr
);
    localparam ST_IDLE  = `PSR_ST_IDLE;
    localparam ST_ADDR  = `PSR_ST_ADDR;
    localparam ST_ACK_A = `PSR_ST_ACK_A;
    localparam ST_PTR   = `PSR_ST_PTR;
    localparam ST_ACK_P = `PSR_ST_ACK_P;
    localparam ST_WDATA = `PSR_ST_WDATA;
    localparam ST_ACK_W = `PSR_ST_ACK_W;
    localparam ST_RDATA = `PSR_ST_RDATA;
    localparam ST_MACK  = `PSR_ST_MACK;

    reg       scl_q_r;
    reg       sda_q_r;
    reg [3:0] state_r;
    reg [3:0] cnt_r;
    reg [7:0] sh_r;
    reg [7:0] ptr_r;
    reg       drive_r;
    reg       rw_r;
    reg       nack_r;

    // line events; start and stop are data edges while clock is high
    wire scl_rise = scl_i & ~scl_q_r;
    wire scl_fall = ~scl_i & scl_q_r;
    wire start_ev = scl_i & scl_q_r & sda_q_r & ~sda_i;
    wire stop_ev  = scl_i & scl_q_r & ~sda_q_r & sda_i;

    assign sda_o    = 1'b0;
    assign sda_oe   = drive_r;
    assign reg_addr = ptr_r;

    // previous line levels for edge detection
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
        end
    end

    // byte engine: sample on rising clock, change data on falling clock
    always @(posedge clk)
    begin
        wr_stb <= 1'b0;
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            sh_r    <= 8'h00;
            ptr_r   <= 8'h00;
            drive_r <= 1'b0;
            rw_r    <= 1'b0;
            nack_r  <= 1'b0;
            wr_data <= 8'h00;
        end
        else if (start_ev)
        begin
            state_r <= ST_ADDR;
            cnt_r   <= 4'h0;
            drive_r <= 1'b0;
        end
        else if (stop_ev)
        begin
            state_r <= ST_IDLE;
            drive_r <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (state_r == ST_MACK)
                nack_r <= sda_i;
            else if (state_r != ST_IDLE)
            begin
                if (state_r != ST_RDATA)
                    sh_r <= {sh_r[6:0], sda_i};
                cnt_r <= cnt_r + 4'h1;
            end
        end
        else if (scl_fall)
        begin
            case (state_r)
            ST_ADDR:
                if (cnt_r == `PSR_BYTE_BITS)
                begin
                    // only our own address is acknowledged
                    if (sh_r[7:1] == `PSR_I2C_ADDR)
                    begin
                        rw_r    <= sh_r[0];
                        drive_r <= 1'b1;
                        state_r <= ST_ACK_A;
                    end
                    else
                        state_r <= ST_IDLE;
                end
            ST_PTR:
                if (cnt_r == `PSR_BYTE_BITS)
                begin
                    ptr_r   <= sh_r;
                    drive_r <= 1'b1;
                    state_r <= ST_ACK_P;
                end
            ST_WDATA:
                if (cnt_r == `PSR_BYTE_BITS)
                begin
                    wr_stb  <= 1'b1;
                    wr_data <= sh_r;
                    drive_r <= 1'b1;
                    state_r <= ST_ACK_W;
                end
            ST_ACK_A:
            begin
                cnt_r <= 4'h0;
                if (rw_r)
                begin
                    sh_r    <= rd_data;
                    drive_r <= ~rd_data[7];
                    ptr_r   <= ptr_r + 8'h01;
                    state_r <= ST_RDATA;
                end
                else
                begin
                    drive_r <= 1'b0;
                    state_r <= ST_PTR;
                end
            end
            ST_ACK_P:
            begin
                cnt_r   <= 4'h0;
                drive_r <= 1'b0;
                state_r <= ST_WDATA;
            end
            ST_ACK_W:
            begin
                // pointer advances so bursts fill successive registers
                cnt_r   <= 4'h0;
                drive_r <= 1'b0;
                ptr_r   <= ptr_r + 8'h01;
                state_r <= ST_WDATA;
            end
            ST_RDATA:
                if (cnt_r == `PSR_BYTE_BITS)
                begin
                    drive_r <= 1'b0;
                    state_r <= ST_MACK;
                end
                else
                begin
                    sh_r    <= {sh_r[6:0], 1'b0};
                    drive_r <= ~sh_r[6];
                end
            ST_MACK:
                if (nack_r)
                    state_r <= ST_IDLE;
                else
                begin
                    cnt_r   <= 4'h0;
                    sh_r    <= rd_data;
                    drive_r <= ~rd_data[7];
                    ptr_r   <= ptr_r + 8'h01;
                    state_r <= ST_RDATA;
                end
            default:
                state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // psr_i2c_slave

// file: hw/psr_regbank.v
`include "psr_regs.vh"

// Behaviour
// - Bit 7 of the output-good status register reads the enable pin level.
// - Status bits 6..0 show channels 7..1 output-good, live from the inputs.
// - A zero mask bit passes that channel's good state to the fault output.
// - The mask register takes its reset value from the fuse inputs.
// - Undervoltage flags 6..0 set on channels 7..1 events, zero after reset.
// - Overvoltage flags 5..0 set for channels 6..1; channel 7 has none.
// - A flag holds until the host writes one to it; a zero leaves it.
// - Mode bits 5..0 pick forced PWM at 0, auto power-save at 1, fuse reset.
// - Sequencer bits 6..0 pick host manual control at 0, sequencer at 1.
// - Channel 6 bit 4 picks buck-boost at 0, buck only at 1, fuse reset.
// - Channel 6 bits 1:0 hold the boost kick-in threshold code.
// - The boost threshold acts only while channel 6 is in buck-boost mode.
// - Manual-mode channels are switched by the host's per-channel enables.
// - Channel 5 and 6 auto DCM is allowed only when both use power-save.
module psr_regbank (
    input  wire       clk,              // 25 MHz system clock
    input  wire       rst_n,            // synchronous reset, active low
    input  wire       scl_i,            // two-wire clock level
    input  wire       sda_i,            // two-wire data level
    output wire       sda_o,            // data out, always low
    output wire       sda_oe,           // high while pulling data low
    input  wire       enable_pin,       // external enable pin level
    input  wire [6:0] output_good,      // per-channel good, ch7..ch1
    input  wire [6:0] uv_event,         // undervoltage seen, ch7..ch1
    input  wire [5:0] ov_event,         // overvoltage seen, ch6..ch1
    input  wire [6:0] fuse_good_mask,   // fuse default of mask
    input  wire [5:0] fuse_psave,       // fuse default of switching mode
    input  wire [6:0] fuse_seq,         // fuse default of sequencer select
    input  wire       fuse_ch6_buck,    // fuse default of buck-only bit
    input  wire [1:0] fuse_ch6_vth,     // fuse default of boost threshold
    output reg        fault_n,          // fault output, active low
    output wire [5:0] power_save_mode,  // 1 = auto pwm/power-save
    output wire [6:0] sequencer_ctl,    // 1 = sequencer owns channel
    output wire [6:0] channel_manual,   // 1 = host enable bits own channel
    output wire       ch6_step_down_only, // 1 = buck only
    output wire [1:0] ch6_boost_threshold, // active threshold code
    output wire       ch6_boost_vth_act,  // threshold code in effect
    output wire       ch56_discontinuous_ok // dcm may be selected
);
    wire [7:0] reg_addr;
    wire       wr_stb;
    wire [7:0] wr_data;
    wire [7:0] rd_data;

    reg  [6:0] good_mask_r;
    reg  [6:0] uv_flags_r;
    wire [6:0] uv_flags_nxt;
    reg  [5:0] ov_flags_r;
    wire [5:0] ov_flags_nxt;
    reg  [5:0] psave_r;
    reg  [6:0] seq_r;
    reg        ch6_buck_r;
    reg  [1:0] ch6_vth_r;

    // byte-wide two-wire slave with auto-incrementing pointer
    psr_i2c_slave u_link (
        .clk      (clk),
        .rst_n    (rst_n),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe),
        .reg_addr (reg_addr),
        .wr_stb   (wr_stb),
        .wr_data  (wr_data),
        .rd_data  (rd_data)
    );

    // write hit on one register offset; shared by every write process
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        input       stb;
        begin
            hit = stb & (addr == ofs);
        end
    endfunction

    // read mux; unmapped offsets and unused bits read zero
    // status is sampled when a read byte is loaded, not bit by bit
    function [7:0] rd_mux;
        input [7:0] addr;
        input [7:0] status;
        input [6:0] mask;
        input [6:0] uv;
        input [5:0] ov;
        input [5:0] psv;
        input [6:0] seq;
        input       buck;
        input [1:0] vth;
        begin
            case (addr)
            `PSR_OFS_GOOD_STATUS: rd_mux = status;
            `PSR_OFS_GOOD_MASK:   rd_mux = {1'b0, mask};
            `PSR_OFS_UV_FLAGS:    rd_mux = {1'b0, uv};
            `PSR_OFS_OV_FLAGS:    rd_mux = {2'b00, ov};
            `PSR_OFS_PSAVE_SEL:   rd_mux = {2'b00, psv};
            `PSR_OFS_SEQ_SEL:     rd_mux = {1'b0, seq};
            `PSR_OFS_CH6_CFG:     rd_mux = {3'b000, buck, 2'b00, vth};
            default:              rd_mux = `PSR_RST_BYTE;
            endcase
        end
    endfunction

    // status is live: enable pin on top, channel good below it
    wire [7:0] status_byte = {enable_pin, output_good};

    // the status offset has no write path at all
    assign rd_data = rd_mux(reg_addr, status_byte, good_mask_r,
                            uv_flags_r, ov_flags_r, psave_r, seq_r,
                            ch6_buck_r, ch6_vth_r);

    // mask register, fuse default caught at reset
    // fuses are taken on every clock while reset is held, so a late settle is harmless
    always @(posedge clk)
    begin
        if (!rst_n)
            good_mask_r <= fuse_good_mask;
        else if (hit(reg_addr, `PSR_OFS_GOOD_MASK, wr_stb))
            good_mask_r <= wr_data[6:0];
    end

    // write-one-clear masks for the two flag registers
    wire [6:0] uv_clr = hit(reg_addr, `PSR_OFS_UV_FLAGS, wr_stb)
                        ? wr_data[6:0] : 7'h00;
    wire [5:0] ov_clr = hit(reg_addr, `PSR_OFS_OV_FLAGS, wr_stb)
                        ? wr_data[5:0] : 6'h00;

    // one sticky cell per channel; an event in the clear cycle wins
    genvar gu;
    generate
        for (gu = 0; gu < 7; gu = gu + 1)
        begin : g_uv
            assign uv_flags_nxt[gu] = uv_event[gu]
                                    | (uv_flags_r[gu] & ~uv_clr[gu]);
        end
        for (gu = 0; gu < 6; gu = gu + 1)
        begin : g_ov
            assign ov_flags_nxt[gu] = ov_event[gu]
                                    | (ov_flags_r[gu] & ~ov_clr[gu]);
        end
    endgenerate

    // flag storage
    // flags have no fuse default; reset always starts them clear
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            uv_flags_r <= `PSR_RST_UV_FLAGS;
            ov_flags_r <= `PSR_RST_OV_FLAGS;
        end
        else
        begin
            uv_flags_r <= uv_flags_nxt;
            ov_flags_r <= ov_flags_nxt;
        end
    end

    // switching-mode select, fuse default
    always @(posedge clk)
    begin
        if (!rst_n)
            psave_r <= fuse_psave;
        else if (hit(reg_addr, `PSR_OFS_PSAVE_SEL, wr_stb))
            psave_r <= wr_data[5:0];
    end

    // sequencer select, fuse default
    always @(posedge clk)
    begin
        if (!rst_n)
            seq_r <= fuse_seq;
        else if (hit(reg_addr, `PSR_OFS_SEQ_SEL, wr_stb))
            seq_r <= wr_data[6:0];
    end

    // channel 6 regulation config, fuse default
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch6_buck_r <= fuse_ch6_buck;
            ch6_vth_r  <= fuse_ch6_vth;
        end
        else if (hit(reg_addr, `PSR_OFS_CH6_CFG, wr_stb))
        begin
            ch6_buck_r <= wr_data[`PSR_BIT_CH6_BUCK_ONLY];
            ch6_vth_r  <=
                wr_data[`PSR_BIT_CH6_VTH_HI:`PSR_BIT_CH6_VTH_LO];
        end
    end

    // fault is registered, so it moves only on a clock edge; a good input low at an edge still pulses it
    // masked channels drop out before the reduction; status stays raw
    always @(posedge clk)
    begin
        if (!rst_n)
            fault_n <= 1'b1;
        else
            fault_n <= ~|(~output_good & ~good_mask_r);
    end

    // mode outputs to the converters and sequencer
    assign power_save_mode    = psave_r;
    assign sequencer_ctl      = seq_r;
    assign channel_manual     = ~seq_r;
    assign ch6_step_down_only = ch6_buck_r;

    // in buck-only mode the code is held back and reads as inactive
    // the stored code is kept and still reads back; a return to buck-boost writes a new code from the same byte
    assign ch6_boost_vth_act   = ~ch6_buck_r;
    assign ch6_boost_threshold = ch6_buck_r ? 2'b00 : ch6_vth_r;

    // dcm gate for channels 5 and 6; the dcm bit itself lives elsewhere
    assign ch56_discontinuous_ok = psave_r[5] & psave_r[4];
endmodule // psr_regbank

// file: verification/psr_checker.sv
module psr_checker (
    input wire logic       clk,                  // clock
    input wire logic       rst_n,                // reset, low
    input wire logic       scl_i,                // link clock
    input wire logic       sda_oe,               // device pulls data
    input wire logic [6:0] output_good,          // good, ch7..1
    input wire logic [5:0] fuse_psave,           // fuse modes
    input wire logic [6:0] fuse_seq,             // fuse sequencer
    input wire logic       fault_n,              // fault, low
    input wire logic [5:0] power_save_mode,      // modes
    input wire logic [6:0] sequencer_ctl,        // sequencer
    input wire logic [6:0] channel_manual,       // manual
    input wire logic       ch6_step_down_only,   // buck only
    input wire logic [1:0] ch6_boost_threshold,  // vth code
    input wire logic       ch6_boost_vth_act,    // vth in use
    input wire logic       ch56_discontinuous_ok // dcm allowed
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // fault output only follows real channel drops
    chk_fault_cause:
        assert property (!fault_n |-> $past(output_good) != 7'h7f)
        else $error("fault low with all channels good");
    chk_fault_clear:
        assert property (&output_good |=> fault_n)
        else $error("fault stays low with all channels good");
    // last load before release must be the strap value
    chk_fuse_load:
        assert property ($rose(rst_n) |-> power_save_mode == $past(fuse_psave)
            && sequencer_ctl == $past(fuse_seq))
        else $error("mode registers missed their fuse defaults");
    chk_vth_forced:
        assert property (ch6_step_down_only |-> ch6_boost_threshold == 2'b00)
        else $error("threshold active in buck-only mode");
    chk_vth_flag:
        assert property (ch6_boost_vth_act != ch6_step_down_only)
        else $error("threshold flag disagrees with mode");
    chk_manual_own:
        assert property (channel_manual == ~sequencer_ctl)
        else $error("manual set is not the sequencer complement");
    chk_dcm_gate:
        assert property (ch56_discontinuous_ok == &power_save_mode[5:4])
        else $error("dcm permission wrong");
    // config may only move in a write ack slot, scl held low
    chk_cfg_by_write:
        assert property ($past(rst_n) && $changed({power_save_mode,
            sequencer_ctl, ch6_step_down_only, ch6_boost_threshold})
            |-> sda_oe && !scl_i && !$past(scl_i))
        else $error("config changed outside a register write");
endmodule // psr_checker

bind psr_regbank psr_checker chk_u (.clk, .rst_n, .scl_i, .sda_oe,
    .output_good, .fuse_psave, .fuse_seq, .fault_n, .power_save_mode,
    .sequencer_ctl, .channel_manual, .ch6_step_down_only,
    .ch6_boost_threshold, .ch6_boost_vth_act, .ch56_discontinuous_ok);

// file: verification/psr_host_model.sv
`include "psr_regs.vh"

module psr_host_model (
    input  wire logic clk,  // bench clock
    input  wire logic sda,  // resolved data wire
    output logic      scl,  // serial clock, idle high
    output logic      pull  // high while host pulls data low
);
    timeunit 1ns;
    timeprecision 1ns;

    // link idles released
    initial
    begin
        scl = 1'b1;
        pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // data moves only while scl is low; sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        pull <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl <= 1'b0;
        tick(1);
    endtask

    // start or repeated start: data falls while scl is high
    task automatic start_cond;
        pull <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        pull <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask

    // stop: data rises while scl is high
    task automatic stop_cond;
        pull <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        pull <= 1'b0;
        tick(4);
    endtask

    // msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ack_in, a);
    endtask

    // pointer then one data byte; a ones pattern clears flags
    task automatic reg_write(input logic [6:0] dev, input logic [7:0] ofs,
                             input logic [7:0] d);
        logic [7:0] rx;
        start_cond();
        xfer({dev, 1'b0}, 1'b1, rx);
        xfer(ofs, 1'b1, rx);
        xfer(d, 1'b1, rx);
        stop_cond();
    endtask

    // pointer write, repeated start, one byte ended by a nack
    task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
        logic [7:0] rx;
        start_cond();
        xfer({`PSR_I2C_ADDR, 1'b0}, 1'b1, rx);
        xfer(ofs, 1'b1, rx);
        start_cond();
        xfer({`PSR_I2C_ADDR, 1'b1}, 1'b1, rx);
        xfer(8'hff, 1'b1, d);
        stop_cond();
    endtask
endmodule // psr_host_model

// file: verification/psr_regbank_tb.sv
`include "psr_regs.vh"

module psr_regbank_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, rst_n, enable_pin, fuse_ch6_buck, exp_f; // bench
    logic [6:0] output_good, uv_event, fuse_good_mask, fuse_seq;
    logic [5:0] ov_event, fuse_psave;                 // events, fuses
    logic [1:0] fuse_ch6_vth;                         // fuse vth
    wire        scl, host_pull, sda_oe, fault_n;      // link, fault
    wire        ch6_step_down_only, ch6_boost_vth_act, ch56_discontinuous_ok;
    wire [5:0]  power_save_mode;                      // modes
    wire [6:0]  sequencer_ctl, channel_manual;        // seq select
    wire [1:0]  ch6_boost_threshold;                  // vth code
    wire        sda = ~(sda_oe | host_pull);          // pulled up
    int         m_mask, m_uv, m_ov, m_psv, m_seq, m_cfg, clr; // model
    int         miscompares, comparisons;             // tallies

    // 25 MHz
    always #20 clk = ~clk;

    psr_regbank dut_u (.clk, .rst_n, .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe, .enable_pin, .output_good, .uv_event, .ov_event,
        .fuse_good_mask, .fuse_psave, .fuse_seq, .fuse_ch6_buck,
        .fuse_ch6_vth, .fault_n, .power_save_mode, .sequencer_ctl,
        .channel_manual, .ch6_step_down_only, .ch6_boost_threshold,
        .ch6_boost_vth_act, .ch56_discontinuous_ok);
    psr_host_model host_u (.clk, .sda, .scl, .pull(host_pull));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] ofs, input int exp);
        logic [7:0] d;
        host_u.reg_read(ofs, d);
        check(d, 8'(exp));
    endtask

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // a hang costs a mismatch, run needs about 36k cycles
    initial
    begin
        repeat (80000) @(posedge clk);
        miscompares++;
        wrap_up();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        enable_pin = 1'b0;
        output_good = 7'h00;
        uv_event = 7'h00;
        ov_event = 6'h00;
        void'($urandom(32'hb8f5));
        {fuse_good_mask, fuse_psave, fuse_seq} = 20'($urandom);
        {fuse_ch6_buck, fuse_ch6_vth} = 3'($urandom);
        m_mask = fuse_good_mask;
        m_psv = fuse_psave;
        m_seq = fuse_seq;
        m_cfg = {fuse_ch6_buck, 2'b00, fuse_ch6_vth};
        m_uv = 0;
        m_ov = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // defaults: straps loaded, flags clear
        rd_chk(8'h18, 0);
        rd_chk(8'h19, m_mask);
        rd_chk(8'h1a, 0);
        rd_chk(8'h1b, 0);
        rd_chk(8'h1c, m_psv);
        rd_chk(8'h1d, m_seq);
        rd_chk(8'h1e, m_cfg);
        $display("test defaults done");
        // status is live and shrugs off host writes
        for (int i = 0; i < 4; i++)
        begin
            enable_pin <= i[0];
            output_good <= 7'($urandom);
            host_u.reg_write(`PSR_I2C_ADDR, 8'h18, 8'($urandom));
            rd_chk(8'h18, {enable_pin, output_good});
        end
        $display("test status done");
        // fault sees only unmasked channels; raw status ignores mask
        for (int i = 0; i < 6; i++)
        begin
            m_mask = (i == 1) ? 'h7f : $urandom & 'h7f;
            output_good <= (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($urandom);
            host_u.reg_write(`PSR_I2C_ADDR, 8'h19, 8'(m_mask) | 8'h80);
            rd_chk(8'h19, m_mask);
            exp_f = ~|(~output_good & ~m_mask[6:0]);
            check({7'h00, fault_n}, {7'h00, exp_f});
            rd_chk(8'h18, {enable_pin, output_good});
        end
        $display("test mask done");
        // flags latch one-cycle events, zeros written leave them alone
        for (int i = 0; i < 4; i++)
        begin
            uv_event <= 7'($urandom);
            ov_event <= 6'($urandom);
            @(posedge clk);
            m_uv |= uv_event;
            m_ov |= ov_event;
            uv_event <= 7'h00;
            ov_event <= 6'h00;
            rd_chk(8'h1a, m_uv);
            rd_chk(8'h1b, m_ov);
            clr = $urandom & 'hff;
            host_u.reg_write(`PSR_I2C_ADDR, 8'h1a, 8'(clr));
            host_u.reg_write(`PSR_I2C_ADDR, 8'h1b, 8'(clr));
            m_uv &= ~clr & 'h7f;
            m_ov &= ~clr & 'h3f;
            rd_chk(8'h1a, m_uv);
            rd_chk(8'h1b, m_ov);
        end
        $display("test flags done");
        // every threshold code in both regulation modes
        for (int i = 0; i < 8; i++)
        begin
            m_psv = (i == 7) ? 'h3f : $urandom & 'h3f;
            m_seq = $urandom & 'h7f;
            m_cfg = (i & 4) << 2 | (i & 3);
            host_u.reg_write(`PSR_I2C_ADDR, 8'h1c, 8'(m_psv) | 8'hc0);
            host_u.reg_write(`PSR_I2C_ADDR, 8'h1d, 8'(m_seq) | 8'h80);
            host_u.reg_write(`PSR_I2C_ADDR, 8'h1e, 8'(m_cfg) | 8'hec);
            rd_chk(8'h1c, m_psv);
            rd_chk(8'h1d, m_seq);
            rd_chk(8'h1e, m_cfg);
            check({2'b00, power_save_mode}, 8'(m_psv));
            check({1'b0, channel_manual}, 8'(~m_seq & 'h7f));
            check({7'h00, ch6_step_down_only}, 8'(i >> 2));
            check({6'h00, ch6_boost_threshold}, 8'(i < 4 ? i : 0));
            check({7'h00, ch6_boost_vth_act}, 8'(i < 4));
            check({1'b0, sequencer_ctl}, 8'(m_seq));
            check({7'h00, ch56_discontinuous_ok}, 8'(m_psv >> 4 == 3));
        end
        $display("test config done");
        // foreign device address and unmapped offset
        host_u.reg_write(`PSR_I2C_ADDR ^ 7'h01, 8'h19, 8'h00);
        rd_chk(8'h19, m_mask);
        rd_chk(8'h25, 0);
        $display("test refusals done");
        wrap_up();
    end
endmodule // psr_regbank_tb
